// >>> core/pfta_top.sv
// Purpose: self-programming table access unit for program flash
// Assumes: core issues table ops and SFR accesses on core_clk
// Notes: flash array and data EEPROM sit outside this block
`include "pfta_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module pfta_top #(
    parameter int PROG_CYCLES = `PFTA_PROG_TIME_US * `PFTA_CLK_MHZ
) (
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic warm_rst,
    // SFR access
    input wire pfta_pkg::pfta_sfr_type sfr_sel,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_reg,
    // Table operations
    input wire logic tbl_req,
    input wire logic tbl_is_write,
    input wire pfta_pkg::pfta_ptr_mode_type tbl_mode,
    output logic tbl_done_reg,
    // Program flash array
    output logic [`PFTA_PTR_W-1:0] flash_rd_addr_reg,
    input wire logic [15:0] flash_rd_word,
    output logic flash_erase_reg,
    output logic flash_prog_reg,
    output logic [`PFTA_PTR_W-1:0] flash_wr_addr_reg,
    output logic [7:0] flash_wr_byte_reg,
    output pfta_pkg::pfta_target_type target_reg,
    // Data EEPROM read strobe
    output logic ee_rd_strobe_reg,
    // Instruction fetch
    input wire logic [15:0] fetch_word,
    input wire logic fetch_is_valid,
    output logic [15:0] exec_word_reg,
    output logic fetch_stall_reg,
    // Write-done flag
    input wire logic done_flag_clr,
    output logic memory_write_done_flag_reg
);
    import pfta_pkg::*;

    localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

    logic mem_select_reg;
    logic config_select_reg;
    logic erase_en_reg;
    logic write_error_flag_reg;
    logic write_enable_bit_reg;
    logic wr_start_reg;
    logic rd_start_reg;
    logic [7:0] table_byte_latch_reg;
    logic [`PFTA_PTR_W-1:0] table_pointer_reg;
    logic [1:0] key_state_reg;
    pfta_seq_type seq_reg;
    logic [31:0] timer_reg;
    logic [5:0] stream_idx_reg;
    logic [`PFTA_PTR_W-1:0] blk_addr_reg;
    logic rd_pend_reg;
    logic rd_low_bit_reg;
    logic [`PFTA_PTR_W-1:0] access_addr;
    logic [`PFTA_PTR_W-1:0] ptr_next;
    logic ctrl_wr;
    logic start_try;
    logic start_ok;
    logic busy;
    logic seq_finish;
    logic tbl_take;
    pfta_target_type target_now;

    pfta_hold_if hold_if ();

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath helpers

    pfta_ptr_unit u_ptr (
        .ptr_cur(table_pointer_reg),
        .mode(tbl_mode),
        .access_addr(access_addr),
        .ptr_next(ptr_next)
    );

    pfta_holding_buf u_hold (
        .core_clk(core_clk),
        .rst(rst),
        .hold(hold_if)
    );

    // Config select overrides memory select
    assign target_now = config_select_reg ? TGT_CONFIG :
                        (mem_select_reg ? TGT_PROGRAM : TGT_EEPROM);
    assign busy = (seq_reg != SEQ_IDLE);
    assign ctrl_wr = sfr_wr && (sfr_sel == SFR_CTRL);
    assign start_try = ctrl_wr && sfr_wdata[`PFTA_CTL_WR_START] && !busy;
    // Only an armed key and write enable let the start through
    assign start_ok = start_try && write_enable_bit_reg && (key_state_reg == 2'd2);
    assign seq_finish = (seq_reg == SEQ_TIMED) && (timer_reg == PROG_LAST);
    // Table requests are not taken while busy, so table ops never race the sequencer
    assign tbl_take = tbl_req && !busy;

    assign hold_if.wr_en = tbl_take && tbl_is_write;
    assign hold_if.wr_idx = access_addr[`PFTA_BLK_LSB-1:0];
    assign hold_if.wr_byte = table_byte_latch_reg;
    assign hold_if.clear = seq_finish && !erase_en_reg;
    assign hold_if.rd_idx = stream_idx_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Unlock key tracking

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_state_reg <= 2'd0;
        end else if (warm_rst || ctrl_wr) begin
            key_state_reg <= 2'd0;
        end else if (sfr_wr && sfr_sel == SFR_KEY) begin
            if (sfr_wdata == `PFTA_KEY_FIRST) begin
                key_state_reg <= 2'd1;
            end else if (sfr_wdata == `PFTA_KEY_SECOND && key_state_reg == 2'd1) begin
                key_state_reg <= 2'd2;
            end else begin
                key_state_reg <= 2'd0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_select_reg <= 1'b0;
            config_select_reg <= 1'b0;
            erase_en_reg <= 1'b0;
            write_error_flag_reg <= 1'b0;
            write_enable_bit_reg <= 1'b0;
            wr_start_reg <= 1'b0;
            rd_start_reg <= 1'b0;
        end else if (warm_rst) begin
            // Selects kept so the failed target stays visible
            erase_en_reg <= 1'b0;
            write_enable_bit_reg <= 1'b0;
            wr_start_reg <= 1'b0;
            rd_start_reg <= 1'b0;
            if (busy) begin
                write_error_flag_reg <= 1'b1;
            end
        end else begin
            rd_start_reg <= 1'b0;
            if (ctrl_wr) begin
                mem_select_reg <= sfr_wdata[`PFTA_CTL_MEM_SEL];
                config_select_reg <= sfr_wdata[`PFTA_CTL_CFG_SEL];
                write_enable_bit_reg <= sfr_wdata[`PFTA_CTL_WR_EN];
                if (!busy) begin
                    erase_en_reg <= sfr_wdata[`PFTA_CTL_ERASE_EN];
                    write_error_flag_reg <= sfr_wdata[`PFTA_CTL_WR_ERR];
                end
                // Read start judged on the select bits already in place
                if (sfr_wdata[`PFTA_CTL_RD_START] && !mem_select_reg && !config_select_reg
                    && !busy) begin
                    rd_start_reg <= 1'b1;
                end
            end
            if (start_ok) begin
                wr_start_reg <= 1'b1;
                write_error_flag_reg <= 1'b1;
            end else if (start_try) begin
                write_error_flag_reg <= 1'b1;
            end
            if (seq_finish) begin
                wr_start_reg <= 1'b0;
                write_error_flag_reg <= 1'b0;
                erase_en_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-timed sequencer

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_reg <= SEQ_IDLE;
            timer_reg <= 32'h00000000;
            stream_idx_reg <= 6'h00;
            blk_addr_reg <= '0;
            target_reg <= TGT_EEPROM;
        end else if (warm_rst) begin
            seq_reg <= SEQ_IDLE;
            timer_reg <= 32'h00000000;
            stream_idx_reg <= 6'h00;
        end else begin
            case (seq_reg)
                SEQ_IDLE: begin
                    timer_reg <= 32'h00000000;
                    stream_idx_reg <= 6'h00;
                    if (start_ok) begin
                        target_reg <= target_now;
                        // Whole 64-byte row; low six pointer bits dropped
                        blk_addr_reg <= {table_pointer_reg[`PFTA_PTR_W-1:`PFTA_BLK_LSB],
                                         6'h00};
                        if (target_now == TGT_EEPROM) begin
                            seq_reg <= SEQ_TIMED;
                        end else if (erase_en_reg) begin
                            seq_reg <= SEQ_ERASE;
                        end else begin
                            seq_reg <= SEQ_STREAM;
                        end
                    end
                end
                SEQ_ERASE: begin
                    seq_reg <= SEQ_TIMED;
                end
                SEQ_STREAM: begin
                    stream_idx_reg <= stream_idx_reg + 6'h01;
                    if (stream_idx_reg == 6'h3F) begin
                        seq_reg <= SEQ_TIMED;
                    end
                end
                SEQ_TIMED: begin
                    timer_reg <= timer_reg + 32'h00000001;
                    if (seq_finish) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Array strobes; blank holding bytes are never sent
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flash_erase_reg <= 1'b0;
            flash_prog_reg <= 1'b0;
            flash_wr_addr_reg <= '0;
            flash_wr_byte_reg <= 8'h00;
        end else begin
            flash_erase_reg <= (seq_reg == SEQ_ERASE) && !warm_rst;
            flash_prog_reg <= (seq_reg == SEQ_STREAM) && !warm_rst
                              && (hold_if.rd_byte != `PFTA_HOLD_BLANK);
            flash_wr_addr_reg <= (seq_reg == SEQ_STREAM) ?
                                 {blk_addr_reg[`PFTA_PTR_W-1:`PFTA_BLK_LSB], stream_idx_reg}
                                 : blk_addr_reg;
            flash_wr_byte_reg <= hold_if.rd_byte;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            memory_write_done_flag_reg <= 1'b0;
        end else if (seq_finish && !warm_rst) begin
            memory_write_done_flag_reg <= 1'b1;
        end else if (done_flag_clr) begin
            memory_write_done_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Table pointer, latch and table reads

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            table_pointer_reg <= '0;
        end else if (sfr_wr && sfr_sel == SFR_PTR_UPPER) begin
            table_pointer_reg[21:16] <= sfr_wdata[5:0];
        end else if (sfr_wr && sfr_sel == SFR_PTR_HIGH) begin
            table_pointer_reg[15:8] <= sfr_wdata;
        end else if (sfr_wr && sfr_sel == SFR_PTR_LOW) begin
            table_pointer_reg[7:0] <= sfr_wdata;
        end else if (tbl_take) begin
            table_pointer_reg <= ptr_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_pend_reg <= 1'b0;
            rd_low_bit_reg <= 1'b0;
            flash_rd_addr_reg <= '0;
            tbl_done_reg <= 1'b0;
        end else begin
            rd_pend_reg <= tbl_take && !tbl_is_write;
            tbl_done_reg <= (tbl_take && tbl_is_write) || rd_pend_reg;
            if (tbl_take && !tbl_is_write) begin
                flash_rd_addr_reg <= access_addr;
                rd_low_bit_reg <= access_addr[0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            table_byte_latch_reg <= 8'h00;
        end else if (rd_pend_reg) begin
            // Odd address takes the upper half of the word
            table_byte_latch_reg <= rd_low_bit_reg ? flash_rd_word[15:8]
                                                   : flash_rd_word[7:0];
        end else if (sfr_wr && sfr_sel == SFR_LATCH) begin
            table_byte_latch_reg <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SFR readback, EEPROM strobe and fetch path

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_reg <= 8'h00;
        end else begin
            case (sfr_sel)
                SFR_CTRL: begin
                    sfr_rdata_reg <= {mem_select_reg, config_select_reg, 1'b0, erase_en_reg,
                                      write_error_flag_reg, write_enable_bit_reg,
                                      wr_start_reg, rd_start_reg};
                end
                SFR_KEY: begin
                    sfr_rdata_reg <= 8'h00;
                end
                SFR_LATCH: begin
                    sfr_rdata_reg <= table_byte_latch_reg;
                end
                SFR_PTR_UPPER: begin
                    sfr_rdata_reg <= {2'b00, table_pointer_reg[21:16]};
                end
                SFR_PTR_HIGH: begin
                    sfr_rdata_reg <= table_pointer_reg[15:8];
                end
                SFR_PTR_LOW: begin
                    sfr_rdata_reg <= table_pointer_reg[7:0];
                end
                default: begin
                    sfr_rdata_reg <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ee_rd_strobe_reg <= 1'b0;
        end else begin
            ee_rd_strobe_reg <= ctrl_wr && sfr_wdata[`PFTA_CTL_RD_START] && !mem_select_reg
                                && !config_select_reg && !busy;
        end
    end

    // EEPROM writes run the timer too but leave fetch alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetch_stall_reg <= 1'b0;
            exec_word_reg <= `PFTA_NOP_WORD;
        end else begin
            fetch_stall_reg <= (busy && !seq_finish && !warm_rst && target_reg != TGT_EEPROM)
                               || (start_ok && target_now != TGT_EEPROM);
            exec_word_reg <= fetch_is_valid ? fetch_word : `PFTA_NOP_WORD;
        end
    end
endmodule

// >>> core/pfta_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 50 MHz core clock
// Notes: included by bare name
`ifndef PFTA_CONSTS_SVH
`define PFTA_CONSTS_SVH

// Control register fields
`define PFTA_CTL_MEM_SEL 7
`define PFTA_CTL_CFG_SEL 6
`define PFTA_CTL_ERASE_EN 4
`define PFTA_CTL_WR_ERR 3
`define PFTA_CTL_WR_EN 2
`define PFTA_CTL_WR_START 1
`define PFTA_CTL_RD_START 0
`define PFTA_CTL_RESET 8'h00

// Unlock key values
`define PFTA_KEY_FIRST 8'h55
`define PFTA_KEY_SECOND 8'hAA

// Holding buffer and pointer geometry
`define PFTA_HOLD_DEPTH 64
`define PFTA_HOLD_BLANK 8'hFF
`define PFTA_PTR_W 22
`define PFTA_PTR_AUTO_W 21
`define PFTA_BLK_LSB 6
`define PFTA_NOP_WORD 16'h0000

// Self-timed programming time
`define PFTA_CLK_MHZ 50
`define PFTA_PROG_TIME_US 2000

`endif

// >>> core/pfta_pkg.sv
// Purpose: shared types of the table access unit
// Assumes: nothing
// Notes: numbers live in pfta_consts.svh
package pfta_pkg;
    typedef enum logic [1:0] {
        PTR_KEEP,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } pfta_ptr_mode_type;

    typedef enum logic [2:0] {
        SFR_CTRL,
        SFR_KEY,
        SFR_LATCH,
        SFR_PTR_UPPER,
        SFR_PTR_HIGH,
        SFR_PTR_LOW
    } pfta_sfr_type;

    typedef enum logic [1:0] {
        TGT_EEPROM,
        TGT_PROGRAM,
        TGT_CONFIG
    } pfta_target_type;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_ERASE,
        SEQ_STREAM,
        SEQ_TIMED
    } pfta_seq_type;
endpackage

// >>> core/pfta_hold_if.sv
// Purpose: link between sequencer and holding buffer
// Assumes: single core clock
// Notes: read port is combinational
interface pfta_hold_if;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [7:0] wr_byte;
    logic clear;
    logic [5:0] rd_idx;
    logic [7:0] rd_byte;

    modport ctrl (output wr_en, output wr_idx, output wr_byte, output clear,
                  output rd_idx, input rd_byte);
    modport store (input wr_en, input wr_idx, input wr_byte, input clear,
                   input rd_idx, output rd_byte);
endinterface

// >>> core/pfta_ptr_unit.sv
// Purpose: access address and next pointer for table operations
// Assumes: mode valid with the request
// Notes: top pointer bit never moves
`include "pfta_consts.svh"
module pfta_ptr_unit (
    // Pointer and treatment
    input wire logic [`PFTA_PTR_W-1:0] ptr_cur,
    input wire pfta_pkg::pfta_ptr_mode_type mode,
    // Results
    output logic [`PFTA_PTR_W-1:0] access_addr,
    output logic [`PFTA_PTR_W-1:0] ptr_next
);
    import pfta_pkg::*;

    // Wraps inside the low field, top bit carried through
    function automatic logic [`PFTA_PTR_W-1:0] step(input logic [`PFTA_PTR_W-1:0] p,
                                                    input logic up);
        logic [`PFTA_PTR_AUTO_W-1:0] low;
        low = p[`PFTA_PTR_AUTO_W-1:0];
        low = up ? low + 21'h000001 : low - 21'h000001;
        step = {p[`PFTA_PTR_W-1], low};
    endfunction

    always_comb begin
        access_addr = ptr_cur;
        ptr_next = ptr_cur;
        case (mode)
            PTR_KEEP: begin
                ptr_next = ptr_cur;
            end
            PTR_POST_INC: begin
                ptr_next = step(ptr_cur, 1'b1);
            end
            PTR_POST_DEC: begin
                ptr_next = step(ptr_cur, 1'b0);
            end
            PTR_PRE_INC: begin
                access_addr = step(ptr_cur, 1'b1);
                ptr_next = access_addr;
            end
            default: begin
                ptr_next = ptr_cur;
            end
        endcase
    end
endmodule

// >>> core/pfta_holding_buf.sv
// Purpose: 64 byte-wide program holding registers
// Assumes: one write per cycle
// Notes: clear returns every byte to blank
`include "pfta_consts.svh"
module pfta_holding_buf (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sequencer side
    pfta_hold_if.store hold
);
    import pfta_pkg::*;

    logic [7:0] hold_mem_reg [`PFTA_HOLD_DEPTH];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `PFTA_HOLD_DEPTH; i++) begin
                hold_mem_reg[i] <= `PFTA_HOLD_BLANK;
            end
        end else if (hold.clear) begin
            for (int i = 0; i < `PFTA_HOLD_DEPTH; i++) begin
                hold_mem_reg[i] <= `PFTA_HOLD_BLANK;
            end
        end else if (hold.wr_en) begin
            hold_mem_reg[hold.wr_idx] <= hold.wr_byte;
        end
    end

    assign hold.rd_byte = hold_mem_reg[hold.rd_idx];
endmodule

// >>> core/pfta_top_end.sv
// Purpose: none
// Assumes: none
// Notes: none

// >>> sim/pfta_flash_model.sv
// Purpose: program flash array seen by the table access unit
// Assumes: combinational word read
// Notes: data derived from the address, top bit folded in
module pfta_flash_model (
    // Read port
    input wire logic [21:0] flash_rd_addr_reg,
    output logic [15:0] flash_rd_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // Odd byte high, even byte low; bit 21 shows up in the low byte
    assign flash_rd_word = {flash_rd_addr_reg[8:1] ^ 8'h3C, flash_rd_addr_reg[21:14]};
endmodule

// >>> sim/pfta_top_chk.sv
// Purpose: port-level checker for the table access unit
// Assumes: single clock, async reset
// Notes: bound into pfta_top
module pfta_top_chk #(
    parameter int PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register access
    input wire pfta_pkg::pfta_sfr_type sfr_sel,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata_reg,
    // Table ops and flash strobes
    input wire logic tbl_req,
    input wire logic tbl_done_reg,
    input wire logic flash_erase_reg,
    input wire logic flash_prog_reg,
    input wire logic ee_rd_strobe_reg,
    // Fetch and flag
    input wire logic fetch_is_valid,
    input wire logic [15:0] fetch_word,
    input wire logic [15:0] exec_word_reg,
    input wire logic fetch_stall_reg,
    input wire logic done_flag_clr,
    input wire logic memory_write_done_flag_reg
);
    import pfta_pkg::*;
    // Slack covers launch and drop edges around stream plus timer
    localparam int STALL_MAX = 64 + PROG_CYCLES + 4;
    int stall_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) stall_cnt <= 0;
        else stall_cnt <= fetch_stall_reg ? stall_cnt + 1 : 0;
    end
    sequence s_start_wr;
        sfr_wr && sfr_sel == SFR_CTRL && sfr_wdata[1];
    endsequence
    sequence s_erase_quiet;
        !flash_erase_reg [*8];
    endsequence
    a_key_reads_zero: assert property (sfr_sel == SFR_KEY |=> sfr_rdata_reg == 8'h00)
        else $error("unlock key read not zero");
    a_invalid_nop: assert property (!fetch_is_valid |=> exec_word_reg == 16'h0000)
        else $error("invalid word not executed as nop");
    a_valid_pass: assert property (fetch_is_valid |=> exec_word_reg == $past(fetch_word))
        else $error("valid word not passed to execute");
    a_strobe_in_stall: assert property (flash_erase_reg || flash_prog_reg |-> fetch_stall_reg)
        else $error("flash strobe outside stall");
    a_stall_cause: assert property ($rose(fetch_stall_reg) |-> $past(sfr_wr && sfr_sel == SFR_CTRL && sfr_wdata[1]))
        else $error("stall without start write");
    a_start_stall: assert property (s_start_wr ##1 fetch_stall_reg |-> $past(sfr_wdata[7]) || $past(sfr_wdata[6]))
        else $error("stall on eeprom target");
    a_done_sticky: assert property (memory_write_done_flag_reg && !done_flag_clr |=> memory_write_done_flag_reg)
        else $error("done flag dropped");
    a_ee_pulse: assert property (ee_rd_strobe_reg |=> !ee_rd_strobe_reg)
        else $error("eeprom read strobe too long");
    a_stall_bound: assert property (stall_cnt <= STALL_MAX)
        else $error("stall outlasts timer");
    a_erase_once: assert property (flash_erase_reg |=> s_erase_quiet)
        else $error("repeated erase strobe");
    a_done_cause: assert property (tbl_done_reg |-> $past(tbl_req) || $past(tbl_req, 2))
        else $error("table done without request");
endmodule
bind pfta_top pfta_top_chk #(.PROG_CYCLES(PROG_CYCLES)) u_pfta_top_chk (.core_clk, .rst,
    .sfr_sel, .sfr_wr, .sfr_wdata, .sfr_rdata_reg, .tbl_req, .tbl_done_reg, .flash_erase_reg,
    .flash_prog_reg, .ee_rd_strobe_reg, .fetch_is_valid, .exec_word_reg, .fetch_stall_reg,
    .done_flag_clr, .memory_write_done_flag_reg, .fetch_word);

// >>> sim/program_flash_table_access_bench.sv
// Purpose: self-checking bench for the table access unit
// Assumes: short programming timer
// Notes: strobes logged and compared at the end
module program_flash_table_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pfta_pkg::*;
    logic core_clk = 0, rst = 1, warm_rst = 0, sfr_wr = 0, tbl_req = 0, tbl_is_write = 0;
    logic fetch_is_valid = 0, done_flag_clr = 0, tbl_done_reg, flash_erase_reg, flash_prog_reg;
    logic ee_rd_strobe_reg, fetch_stall_reg, memory_write_done_flag_reg;
    pfta_sfr_type sfr_sel = SFR_CTRL;
    pfta_ptr_mode_type tbl_mode = PTR_KEEP;
    pfta_target_type tgt;
    logic [7:0] sfr_wdata = 8'h00, sfr_rdata_reg, flash_wr_byte_reg, rd;
    logic [15:0] flash_rd_word, fetch_word = 16'h0000, exec_word_reg;
    logic [21:0] flash_rd_addr_reg, flash_wr_addr_reg, p, v;
    logic [30:0] seen[$], want[$];
    int n_fail = 0, checks = 0, n_ee = 0, k;
    always #10 core_clk = ~core_clk;
    pfta_top #(.PROG_CYCLES(20)) u_pfta_top (.core_clk, .rst, .warm_rst, .sfr_sel, .sfr_wr,
        .sfr_wdata, .sfr_rdata_reg, .tbl_req, .tbl_is_write, .tbl_mode, .tbl_done_reg,
        .flash_rd_addr_reg, .flash_rd_word, .flash_erase_reg, .flash_prog_reg,
        .flash_wr_addr_reg, .flash_wr_byte_reg, .target_reg(tgt), .ee_rd_strobe_reg, .fetch_word,
        .fetch_is_valid, .exec_word_reg, .fetch_stall_reg, .done_flag_clr,
        .memory_write_done_flag_reg);
    pfta_flash_model u_pfta_flash_model (.flash_rd_addr_reg, .flash_rd_word);
    always @(posedge core_clk) begin
        if (flash_erase_reg || flash_prog_reg)
            seen.push_back({flash_erase_reg, flash_wr_addr_reg, flash_prog_reg ? flash_wr_byte_reg : 8'h00});
        n_ee += ee_rd_strobe_reg;
    end
    always @(negedge core_clk) begin
        fetch_word <= 16'($urandom);
        fetch_is_valid <= 1'($urandom);
    end
    function automatic logic [7:0] mb(logic [21:0] a);
        return a[0] ? a[8:1] ^ 8'h3C : a[21:14];
    endfunction
    function automatic logic [21:0] nx(logic [21:0] a, logic [20:0] d);
        return {a[21], a[20:0] + d};
    endfunction
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic w(pfta_sfr_type s, logic [7:0] d);
        @(negedge core_clk);
        sfr_sel = s;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge core_clk);
        sfr_wr = 0;
    endtask
    task automatic r(pfta_sfr_type s, logic [7:0] e);
        @(negedge core_clk);
        sfr_sel = s;
        @(negedge core_clk);
        chk(sfr_rdata_reg, e);
    endtask
    task automatic setp(logic [21:0] x);
        w(SFR_PTR_UPPER, {2'b00, x[21:16]});
        w(SFR_PTR_HIGH, x[15:8]);
        w(SFR_PTR_LOW, x[7:0]);
        p = x;
    endtask
    task automatic t(logic wr, pfta_ptr_mode_type m);
        @(negedge core_clk);
        tbl_is_write = wr;
        tbl_mode = m;
        tbl_req = 1;
        @(negedge core_clk);
        tbl_req = 0;
        chk(tbl_done_reg, wr);
        @(negedge core_clk);
        chk(tbl_done_reg, !wr);
    endtask
    // Enable is stored first; the start write must follow the keys directly
    task automatic start(logic [7:0] c);
        w(SFR_CTRL, c);
        w(SFR_KEY, 8'h55);
        w(SFR_KEY, 8'hAA);
        w(SFR_CTRL, c | 8'h02);
    endtask
    task automatic done_wait;
        for (k = 0; k < 300 && fetch_stall_reg !== 1'b0; k++) @(negedge core_clk);
        if (k == 300) begin
            n_fail++;
            stop_test();
        end
        chk(memory_write_done_flag_reg, 1);
        done_flag_clr = 1;
        @(negedge core_clk);
        done_flag_clr = 0;
        chk(memory_write_done_flag_reg, 0);
    endtask
    initial begin
        void'($urandom(32'hE4E0F7C8));
        repeat (2) @(negedge core_clk);
        rst = 0;
        r(SFR_CTRL, 8'h00);
        w(SFR_KEY, 8'h55);
        r(SFR_KEY, 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (i % 4 == 0) setp(i == 0 ? 22'($urandom) : 22'h3FFFFF);
            v = (i % 4 == 3) ? nx(p, 1) : p;
            t(0, pfta_ptr_mode_type'(i % 4));
            p = (i % 4 == 1 || i % 4 == 3) ? nx(p, 1) : (i % 4 == 2) ? nx(p, 21'h1FFFFF) : p;
            r(SFR_LATCH, mb(v));
            r(SFR_PTR_UPPER, {2'b00, p[21:16]});
            r(SFR_PTR_LOW, p[7:0]);
        end
        w(SFR_CTRL, 8'h01);
        w(SFR_CTRL, 8'h80);
        w(SFR_CTRL, 8'h81);
        @(negedge core_clk);
        chk(n_ee, 1);
        w(SFR_CTRL, 8'h86);
        r(SFR_CTRL, 8'h8C);
        setp(22'($urandom));
        want.push_back({1'b1, p[21:6], 6'h00, 8'h00});
        start(8'h94);
        chk(fetch_stall_reg, 1);
        chk(tgt, TGT_PROGRAM);
        done_wait();
        r(SFR_CTRL, 8'h84);
        v = 22'($urandom);
        setp({v[21:6], 6'h21});
        for (int i = 0; i < 2; i++) begin
            rd = 8'($urandom % 255);
            w(SFR_LATCH, rd);
            t(1, PTR_POST_INC);
            want.push_back({1'b0, p, rd});
            p = nx(p, 1);
        end
        start(8'h84);
        done_wait();
        // Holding bytes are blank now, so this run must not program anything
        start(8'h84);
        repeat (70) @(negedge core_clk);
        warm_rst = 1;
        @(negedge core_clk);
        warm_rst = 0;
        r(SFR_CTRL, 8'h88);
        chk(fetch_stall_reg, 0);
        // Config space run with blank holding bytes: stalls, programs nothing
        start(8'h44);
        chk(tgt, TGT_CONFIG);
        done_wait();
        w(SFR_CTRL, 8'h41);
        @(negedge core_clk);
        chk(n_ee, 1);
        chk(seen.size(), want.size());
        foreach (want[i]) chk(seen[i], want[i]);
        stop_test();
    end
endmodule
